//--- scbp_defines.vh
// Constants for the sub-CPU bus port
`ifndef SCBP_DEFINES_VH
`define SCBP_DEFINES_VH
`define SCBP_REG_BASE     16'h0000
`define SCBP_REG_LIMIT    16'h00FF
`define SCBP_RAM_BASE     16'h8000
`define SCBP_RAM_WIDTH    15
`define SCBP_RAM_AW_SIM   10
`define SCBP_TIE_COUNT    8'hFF
`endif

//--- scbp_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module scbp_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  // Resets to zero; callers invert active-low pins first so idle reads as zero
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

//--- scbp_port.v
// Sub-CPU bus port: muxed address/data slave toward the microcontroller
//
// Contract
// - Strap RAM data bit 7 at power-on reset to set the CPU reset polarity.
// - Read strobe held low permanently makes the write strobe a read/write line.
// - Write strobe always wins over read strobe; both active means a write.
// - Low address is captured from the muxed bus while the latch strobe is high.
// - Host-interface interrupt drives its open-drain line low only while pending.
// - Drive block and serial port interrupts use a second open-drain line.
// - Each unit's control registers are reachable by ordinary bus cycles.
// - Buffer RAM is directly readable and writable as scratchpad.
`timescale 1ns/100ps
`include "scbp_defines.vh"
module scbp_port (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        por_active,
  input  wire        ram_data_bit7_strap,
  input  wire        cpu_reset_req,
  output reg         cpu_reset_out,
  input  wire [7:0]  muxed_data_low_address_in,
  output reg  [7:0]  muxed_data_low_address_out,
  output wire [7:0]  muxed_data_low_address_oe,
  input  wire [7:0]  high_address_lines,
  input  wire        addr_latch_en,
  input  wire        rd_b,
  input  wire        wr_b,
  input  wire        host_irq_pending,
  output wire        host_irq_out,
  output wire        host_irq_oe,
  input  wire        drive_irq_pending,
  input  wire        uart_irq_pending,
  output wire        drive_uart_irq_out,
  output wire        drive_uart_irq_oe,
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [7:0]  reg_addr,
  output reg  [7:0]  reg_wdata,
  input  wire [7:0]  reg_rdata,
  output reg         ram_wr,
  output reg         ram_rd,
  output reg  [14:0] ram_addr,
  output reg  [7:0]  ram_wdata,
  input  wire [7:0]  ram_rdata,
  input  wire        ram_rvalid
);
  localparam S_IDLE = 3'b001;
  localparam S_RD   = 3'b010;
  localparam S_WAIT = 3'b100;

  wire [7:0] bus_s;
  wire [7:0] hi_s;
  wire       ale_s;
  wire       rd_s;
  wire       wr_s;
  wire       strap_s;
  wire       por_s;

  // Bus and latch strobe pass equal sync delays, so the latched byte stays aligned
  // with the strobe that framed it
  scbp_sync #(.W(8)) u_sync_bus (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (muxed_data_low_address_in),
    .q     (bus_s)
  );
  scbp_sync #(.W(8)) u_sync_hi (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (high_address_lines),
    .q     (hi_s)
  );
  scbp_sync #(.W(5)) u_sync_ctl (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({addr_latch_en, ~rd_b, ~wr_b, ram_data_bit7_strap, por_active}),
    .q     ({ale_s, rd_s, wr_s, strap_s, por_s})
  );

  // Decode of a 16-bit address; used for read and write paths
  function [1:0] addr_sel;
    input [15:0] a;
    begin
      if (a >= `SCBP_RAM_BASE)
        addr_sel = 2'b10;
      else if (a <= `SCBP_REG_LIMIT)
        addr_sel = 2'b01;
      else
        addr_sel = 2'b00;
    end
  endfunction

  reg  [7:0]  low_addr;
  reg         rst_pol_high;
  reg  [2:0]  state;
  reg         drive_data;
  reg         rd_mode_rw;
  reg  [7:0]  rd_low_cnt;
  wire [15:0] full_addr = {hi_s, low_addr};
  wire [1:0]  sel       = addr_sel(full_addr);
  // With the read strobe tied low, wr_b high means read and low means write.
  // Limitation: in that mode the direction must settle before the latch strobe
  // falls, since the cycle is taken as soon as the latch is seen low.
  wire        is_wr     = wr_s;
  wire        is_rd     = rd_mode_rw ? ~wr_s : (rd_s & ~wr_s);
  wire        strobe_on = is_wr | is_rd;
  // A cycle ends when its strobes release or the next latch strobe rises; with
  // the read strobe tied low only the latch strobe can close it.
  wire        cyc_act   = strobe_on & ~ale_s;
  wire        cpu_reset_on = cpu_reset_req | por_s;

  assign muxed_data_low_address_oe = {8{drive_data}};
  assign host_irq_out       = 1'b0;
  assign host_irq_oe        = host_irq_pending;
  assign drive_uart_irq_out = 1'b0;
  assign drive_uart_irq_oe  = drive_irq_pending | uart_irq_pending;

  // Strap caught while the power-on reset is still asserted, after rst_b release.
  // Until a strap is seen the polarity flag reads as active-low.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pol_high  <= 1'b0;
      cpu_reset_out <= 1'b0;
    end else begin
      if (por_s)
        rst_pol_high <= ~strap_s;
      // Active-high output follows the request, active-low output inverts it
      if (rst_pol_high)
        cpu_reset_out <= cpu_reset_on;
      else
        cpu_reset_out <= ~cpu_reset_on;
    end
  end

  // Read strobe held low through many latch-strobe cycles means it is tied low.
  // The flag only records the mode: decode already gives the write strobe priority.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_low_cnt <= 8'h00;
      rd_mode_rw <= 1'b0;
    end else if (!rd_s) begin
      rd_low_cnt <= 8'h00;
      rd_mode_rw <= 1'b0;
    end else if (rd_low_cnt == `SCBP_TIE_COUNT) begin
      rd_mode_rw <= 1'b1;
    end else if (ale_s) begin
      rd_low_cnt <= rd_low_cnt + 8'h01;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      low_addr <= 8'h00;
    else if (ale_s)
      low_addr <= bus_s;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= S_IDLE;
      drive_data <= 1'b0;
      muxed_data_low_address_out <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
      reg_addr  <= 8'h00;
      reg_wdata <= 8'h00;
      ram_addr  <= 15'h0000;
      ram_wdata <= 8'h00;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
      case (state)
        S_IDLE: begin
          drive_data <= 1'b0;
          if (!ale_s && is_wr) begin
            reg_addr  <= full_addr[7:0];
            reg_wdata <= bus_s;
            ram_addr  <= full_addr[14:0];
            ram_wdata <= bus_s;
            reg_wr    <= sel[0];
            ram_wr    <= sel[1];
            state     <= S_WAIT;
          end else if (!ale_s && is_rd) begin
            reg_addr <= full_addr[7:0];
            ram_addr <= full_addr[14:0];
            reg_rd   <= sel[0];
            ram_rd   <= sel[1];
            state    <= S_RD;
          end
        end
        S_RD: begin
          // Unmapped reads return zero rather than floating
          if (sel[1] && ram_rvalid)
            muxed_data_low_address_out <= ram_rdata;
          else if (sel[0])
            muxed_data_low_address_out <= reg_rdata;
          else
            muxed_data_low_address_out <= 8'h00;
          if (!sel[1] || ram_rvalid) begin
            drive_data <= 1'b1;
            state      <= S_WAIT;
          end
          if (!cyc_act)
            state <= S_IDLE;
        end
        S_WAIT: begin
          // A write on the pins releases the bus at once so the two sides never fight
          if (!cyc_act || is_wr) begin
            drive_data <= 1'b0;
          end
          if (!cyc_act)
            state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

//--- scbp_chk.sv
// Concurrent checks on the sub-CPU bus port pins
`timescale 1ns/100ps
module scbp_chk (
  input wire        clk,
  input wire        rst_b,
  input wire        por_active,
  input wire        ram_data_bit7_strap,
  input wire        cpu_reset_out,
  input wire        wr_b,
  input wire [7:0]  muxed_data_low_address_oe,
  input wire [7:0]  high_address_lines,
  input wire        host_irq_pending,
  input wire        host_irq_out,
  input wire        host_irq_oe,
  input wire        drive_irq_pending,
  input wire        uart_irq_pending,
  input wire        drive_uart_irq_out,
  input wire        drive_uart_irq_oe,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire        ram_wr,
  input wire        ram_rd,
  input wire [14:0] ram_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Six cycles leave room for the two-flop sync plus the polarity and output registers
  AST_RST_HIGH: assert property ((por_active && !ram_data_bit7_strap) [*6] |-> cpu_reset_out)
    else $error("cpu reset not high with strap low");
  AST_RST_LOW: assert property ((por_active && ram_data_bit7_strap) [*6] |-> !cpu_reset_out)
    else $error("cpu reset not low with strap high");
  AST_WR_WINS: assert property (!wr_b [*3] |-> muxed_data_low_address_oe == 8'h00)
    else $error("bus driven during a write");
  AST_ONE_DIR: assert property (!(reg_wr && reg_rd) && !(ram_wr && ram_rd))
    else $error("read and write together");
  AST_HOST_ON: assert property (host_irq_pending [*3] |-> host_irq_oe && !host_irq_out)
    else $error("host irq not pulled low");
  AST_HOST_OFF: assert property (!host_irq_pending [*3] |-> !host_irq_oe)
    else $error("host irq pulled without request");
  AST_DRV_IRQ: assert property ((drive_irq_pending || uart_irq_pending) [*3]
    |-> drive_uart_irq_oe && !drive_uart_irq_out)
    else $error("drive irq not pulled low");
  AST_REG_PULSE: assert property (reg_wr |=> !reg_wr)
    else $error("register write pulse too long");
  AST_RAM_ADDR: assert property (ram_wr |-> ram_addr[14:8] == high_address_lines[6:0])
    else $error("ram address high part wrong");
  COV_REG_WR: cover property (reg_wr);
  COV_RAM_RD: cover property (ram_rd);
  COV_DRV_IRQ: cover property (drive_uart_irq_oe);
endmodule
bind scbp_port scbp_chk u_chk (.*);

//--- scbp_mcu.sv
// Microcontroller model running muxed address/data bus cycles
`timescale 1ns/100ps
module scbp_mcu (
  input  wire       clk,
  input  wire       tied,
  input  wire [7:0] dout,
  input  wire [7:0] doe,
  output reg        ale,
  output reg        rd_b,
  output reg        wr_b,
  output reg  [7:0] ha,
  output wire [7:0] din
);
  reg [7:0] drv;
  // Released bus shows the write data or an inverted byte, never a stale one
  assign din = (doe != 8'h00) ? dout : drv;
  initial begin
    ale = 0; rd_b = 1; wr_b = 1; ha = 8'h00; drv = 8'h00;
  end
  task cyc(input r, input w, input [15:0] a, input [7:0] d, output [7:0] q);
    begin
      @(negedge clk) ha = a[15:8];
      drv = a[7:0];
      ale = 1;
      // A read/write line must show the direction before the latch strobe falls
      @(negedge clk);
      if (tied)
        wr_b = !w;
      repeat (3) @(negedge clk);
      ale = 0;
      drv = w ? d : ~a[7:0];
      repeat (2) @(negedge clk);
      rd_b = tied ? 1'b0 : !r;
      wr_b = !w;
      repeat (8) @(posedge clk);
      q = din;
      @(negedge clk) rd_b = tied ? 1'b0 : 1'b1;
      wr_b = 1;
      drv = ~drv;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule

//--- scbp_tb.sv
// Self-checking bench for the sub-CPU bus port
`timescale 1ns/100ps
module testbench;
  reg clk = 0, rst_b = 0, por = 1, strap = 0, req = 0, hp = 0, dp = 0, up = 0, rv = 0;
  integer failures = 0, n_compared = 0, cycles = 0;
  wire [7:0] din, dout, doe, ha, ra, rwd, mwd;
  wire ale, rd_b, wr_b, rout, rw, rr, mw, mr, hio, hoe, dio, doe2;
  wire [14:0] ma;
  reg tied = 0;
  reg [15:0] cap_a, cap_r;
  reg [7:0] cap_d, q;
  always #5 clk = ~clk;
  scbp_mcu mcu (.clk(clk), .dout(dout), .doe(doe), .ale(ale), .rd_b(rd_b), .wr_b(wr_b),
    .ha(ha), .din(din), .tied(tied));
  scbp_port dut (.clk(clk), .rst_b(rst_b), .por_active(por), .ram_data_bit7_strap(strap),
    .cpu_reset_req(req), .cpu_reset_out(rout), .muxed_data_low_address_in(din),
    .muxed_data_low_address_out(dout), .muxed_data_low_address_oe(doe),
    .high_address_lines(ha), .addr_latch_en(ale), .rd_b(rd_b), .wr_b(wr_b),
    .host_irq_pending(hp), .host_irq_out(hio), .host_irq_oe(hoe), .drive_irq_pending(dp),
    .uart_irq_pending(up), .drive_uart_irq_out(dio), .drive_uart_irq_oe(doe2),
    .reg_wr(rw), .reg_rd(rr), .reg_addr(ra), .reg_wdata(rwd), .reg_rdata(8'h5A),
    .ram_wr(mw), .ram_rd(mr), .ram_addr(ma), .ram_wdata(mwd), .ram_rdata(8'hC3),
    .ram_rvalid(rv));
  always @(posedge clk) begin
    rv <= mr;
    if (rw || mw) begin
      cap_a <= rw ? {8'h00, ra} : {1'b1, ma};
      cap_d <= rw ? rwd : mwd;
    end
    if (rr || mr)
      cap_r <= rr ? {8'h00, ra} : {1'b1, ma};
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      close_out;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task settle; repeat (10) @(negedge clk); endtask
  task t_strap;
    begin
      settle; chk(rout, 1);
      strap = 1; settle; chk(rout, 0);
      por = 0; settle; chk(rout, 1);
      req = 1; settle; chk(rout, 0);
      req = 0;
    end
  endtask
  task t_reg;
    begin
      mcu.cyc(0, 1, 16'h0012, 8'hA5, q);
      chk(cap_a, 16'h0012);
      chk(cap_d, 8'hA5);
      mcu.cyc(1, 0, 16'h0034, 8'h00, q); chk(q, 8'h5A);
      chk(cap_r, 16'h0034);
    end
  endtask
  task t_ram;
    begin
      mcu.cyc(0, 1, 16'h8123, 8'h3C, q);
      chk(cap_a, 16'h8123);
      chk(cap_d, 8'h3C);
      mcu.cyc(1, 0, 16'hF0E1, 8'h00, q); chk(q, 8'hC3);
      chk(cap_r, 16'hF0E1);
    end
  endtask
  task t_both;
    begin
      mcu.cyc(1, 1, 16'h0077, 8'h96, q);
      chk(cap_a, 16'h0077);
      chk(cap_d, 8'h96);
      chk(cap_r, 16'hF0E1);
    end
  endtask
  task t_unmap;
    begin
      mcu.cyc(1, 0, 16'h0200, 8'h00, q); chk(q, 8'h00);
      chk(cap_r, 16'hF0E1);
      mcu.cyc(0, 1, 16'h0300, 8'h11, q);
      chk(cap_a, 16'h0077);
    end
  endtask
  task t_tied;
    integer i;
    begin
      tied = 1;
      for (i = 0; i < 66; i = i + 1) begin
        mcu.cyc(0, 1, 16'h0050, i[7:0], q);
        chk(cap_d, i[7:0]);
        mcu.cyc(1, 0, 16'h8010, 8'h00, q);
        chk(q, 8'hC3);
      end
      chk(cap_r, 16'h8010);
    end
  endtask
  task t_irq;
    begin
      hp = 1; settle; chk({hoe, hio, doe2}, 3'b100);
      hp = 0; up = 1; settle; chk({hoe, doe2, dio}, 3'b010);
      up = 0; dp = 1; settle; chk(doe2, 1);
      dp = 0; settle; chk(doe2, 0);
    end
  endtask
  task close_out;
    begin
      if (failures == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1;
    t_strap; t_reg; t_ram; t_both; t_unmap; t_irq;
    t_tied;
    close_out;
  end
endmodule
